// ===== shared/qdac_pkg.sv
// Constants, register map and types of the quad DAC write command decoder
package qdac_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int NV_WRITE_NS   = 25000;
  localparam int NV_WRITE_CYC  = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Channel word: {vref, pd[1:0], gain, data[11:0]}
  localparam int NUM_CH     = 4;
  localparam int CH_W       = 16;
  localparam int FLD_VREF   = 15;
  localparam int FLD_PD_HI  = 14;
  localparam int FLD_PD_LO  = 13;
  localparam int FLD_GAIN   = 12;
  localparam logic [1:0] LAST_CH = 2'h3;

  // Command byte fields
  localparam logic [1:0] FAST_TAG   = 2'h0;
  localparam logic [2:0] CMD_NVWR   = 3'h2;
  localparam logic [2:0] CMD_ADDR   = 3'h3;
  localparam logic [2:0] CMD_VREF   = 3'h4;
  localparam logic [2:0] CMD_PD     = 3'h5;
  localparam logic [2:0] CMD_GAIN   = 3'h6;
  localparam logic [1:0] WF_MULTI   = 2'h0;
  localparam logic [1:0] WF_BAD     = 2'h1;
  localparam logic [1:0] WF_SEQ     = 2'h2;
  localparam logic [1:0] WF_SINGLE  = 2'h3;

  // Register map (byte addresses)
  localparam int         REG_AW       = 8;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [3:0] REG_IN_PAGE  = 4'h1;
  localparam logic [3:0] REG_OUT_PAGE = 4'h2;
  localparam logic [3:0] REG_NV_PAGE  = 4'h3;
  localparam int         ST_IDLE      = 0;
  localparam int         ST_ADDR_LSB  = 1;
  localparam int         ST_NVADR_LSB = 4;

  // Reset values
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam logic [15:0] CH_RST      = 16'h0000;
  localparam logic [2:0]  ADDR_RST    = 3'h0;

  typedef enum {
    S_CMD, S_FAST_HI, S_FAST_LO, S_CH_HI, S_CH_LO, S_ADDR, S_PD2, S_SKIP
  } qdac_state_t;

endpackage

// ===== shared/qdac_reg_if.sv
// Register access carrier between bus slave and decoder core
`timescale 1ns/1ps
interface qdac_reg_if;
  import qdac_pkg::*;
  logic              wr_en;
  logic [REG_AW-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [REG_AW-1:0] rd_addr;
  logic [31:0]       rd_data;

  modport bus  (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport core (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// ===== rtl/qdac_ahb_slave.sv
// AHB-Lite slave front end, zero wait states
`timescale 1ns/1ps
module qdac_ahb_slave import qdac_pkg::*; (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Core side
  qdac_reg_if.bus          regs
);

  logic              wr_pend_q, wr_pend_d;
  logic [REG_AW-1:0] wr_addr_q, wr_addr_d;
  logic [31:0]       hrdata_q, hrdata_d;
  logic              take;
  logic              mapped;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  assign regs.wr_en   = wr_pend_q;
  assign regs.wr_addr = wr_addr_q;
  assign regs.wr_data = hwdata;
  assign regs.rd_addr = haddr[REG_AW-1:0];

  always_comb begin
    take      = hsel && htrans[1] && hready;
    mapped    = (haddr[31:REG_AW] == 24'h000000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
    wr_pend_d = take && hwrite && mapped;
    wr_addr_d = take ? haddr[REG_AW-1:0] : wr_addr_q;
    hrdata_d  = (take && !hwrite && mapped) ? regs.rd_data : 32'h00000000;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h00000000;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata_q  <= hrdata_d;
    end
  end

endmodule // qdac_ahb_slave

// ===== rtl/qdac_cmd_dec.sv
// Quad DAC write command decoder with nonvolatile write timing
//
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module qdac_cmd_dec import qdac_pkg::*; #(
  parameter int NV_WRITE_CYCLES = NV_WRITE_CYC
) (
  // Clock and reset
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  // AHB-Lite register bus
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic                               hreadyout,
  output logic                               hresp,
  output logic [31:0]                        hrdata,
  // Command byte stream from the serial front end
  input  wire logic                          frame_start,
  input  wire logic                          byte_valid,
  input  wire logic [7:0]                    byte_data,
  input  wire logic                          frame_stop,
  // Pins
  input  wire logic                          load_outputs_n_pin,
  output logic                               nv_write_idle_flag,
  // Converter side
  output logic [NUM_CH-1:0][CH_W-1:0]        dac_out_codes,
  output logic [2:0]                         device_address
);

  localparam int CNT_W = $clog2(NV_WRITE_CYCLES + 1);

  qdac_reg_if regs ();

  qdac_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .regs      (regs.bus)
  );

  //////////////////////////////////////////////////////////////////////////////
  // State

  logic                       load_outputs_n_pin_meta_q, load_outputs_n_pin_q;
  qdac_state_t                state_q, state_d;
  logic [1:0]                 ch_q, ch_d;
  logic [1:0]                 mode_q, mode_d;
  logic                       output_update_hold_bit_q, output_update_hold_bit_d;
  logic [7:0]                 hold_q, hold_d;
  logic [NUM_CH-1:0]          pend_q, pend_d;
  logic                       addr_ok_q, addr_ok_d;
  logic [2:0]                 new_addr_q, new_addr_d;
  logic [NUM_CH-1:0][CH_W-1:0] in_q, in_d;
  logic [NUM_CH-1:0][CH_W-1:0] out_q, out_d;
  logic [NUM_CH-1:0][CH_W-1:0] nv_q, nv_d;
  logic [2:0]                 addr_in_q, addr_in_d;
  logic [2:0]                 addr_nv_q, addr_nv_d;
  logic [CNT_W-1:0]           busy_cnt_q, busy_cnt_d;
  logic                       idle_q, idle_d;
  logic                       en_q, en_d;
  logic                       load_outputs_n_pin_low, accept;
  logic                       nv_start, cfg_wr, bad_cmd, addr_apply;

  assign load_outputs_n_pin_low           = !load_outputs_n_pin_q;
  assign nv_write_idle_flag = idle_q;
  assign dac_out_codes      = out_q;
  assign device_address     = addr_in_q;

  //////////////////////////////////////////////////////////////////////////////
  // Load pin synchroniser

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_outputs_n_pin_meta_q <= 1'b1;
      load_outputs_n_pin_q      <= 1'b1;
    end else begin
      load_outputs_n_pin_meta_q <= load_outputs_n_pin;
      load_outputs_n_pin_q      <= load_outputs_n_pin_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command decode

  always_comb begin
    state_d    = state_q;
    ch_d       = ch_q;
    mode_d     = mode_q;
    output_update_hold_bit_d     = output_update_hold_bit_q;
    hold_d     = hold_q;
    pend_d     = pend_q;
    addr_ok_d  = addr_ok_q;
    new_addr_d = new_addr_q;
    in_d       = in_q;
    out_d      = out_q;
    nv_d       = nv_q;
    addr_in_d  = addr_in_q;
    addr_nv_d  = addr_nv_q;
    busy_cnt_d = busy_cnt_q;
    en_d       = en_q;
    nv_start   = 1'b0;
    cfg_wr     = 1'b0;
    bad_cmd    = 1'b0;
    addr_apply = 1'b0;
    accept     = en_q && idle_q;

    if (regs.wr_en && regs.wr_addr == REG_CTRL) begin
      en_d = regs.wr_data[0];
    end
    if (busy_cnt_q != '0) begin
      busy_cnt_d = busy_cnt_q - CNT_W'(1);
    end

    if (frame_start) begin
      state_d   = accept ? S_CMD : S_SKIP;
      addr_ok_d = 1'b0;
    end else if (frame_stop) begin
      addr_apply = addr_ok_q && accept;
      addr_ok_d  = 1'b0;
      state_d    = S_SKIP;
    end else if (byte_valid) begin
      if (!accept) begin
        state_d = S_SKIP;
      end else begin
        case (state_q)
          S_CMD: begin
            if (byte_data[7:6] == FAST_TAG) begin
              hold_d  = byte_data;
              ch_d    = 2'h0;
              state_d = S_FAST_LO;
            end else begin
              case (byte_data[7:5])
                CMD_NVWR: begin
                  if (byte_data[4:3] == WF_BAD) begin
                    bad_cmd = 1'b1;
                    state_d = S_SKIP;
                  end else begin
                    mode_d  = byte_data[4:3];
                    ch_d    = byte_data[2:1];
                    output_update_hold_bit_d  = byte_data[0];
                    pend_d  = '0;
                    state_d = S_CH_HI;
                  end
                end
                CMD_ADDR: begin
                  addr_ok_d = load_outputs_n_pin_low;
                  state_d   = S_ADDR;
                end
                CMD_VREF, CMD_GAIN: begin
                  // selection bits, A in bit 3
                  cfg_wr = 1'b1;
                  for (int i = 0; i < NUM_CH; i++) begin
                    if (byte_data[7:5] == CMD_VREF) begin
                      in_d[i][FLD_VREF]  = byte_data[NUM_CH-1-i];
                      out_d[i][FLD_VREF] = byte_data[NUM_CH-1-i];
                    end else begin
                      in_d[i][FLD_GAIN]  = byte_data[NUM_CH-1-i];
                      out_d[i][FLD_GAIN] = byte_data[NUM_CH-1-i];
                    end
                  end
                  state_d = S_SKIP;
                end
                CMD_PD: begin
                  hold_d  = byte_data;
                  state_d = S_PD2;
                end
                default: begin
                  bad_cmd = 1'b1;
                  state_d = S_SKIP;
                end
              endcase
            end
          end
          S_FAST_HI: begin
            hold_d  = byte_data;
            state_d = S_FAST_LO;
          end
          S_FAST_LO: begin
            // fast write, channels A to D
            in_d[ch_q] = {in_q[ch_q][FLD_VREF], hold_q[5:4], in_q[ch_q][FLD_GAIN], hold_q[3:0], byte_data};
            ch_d       = ch_q + 2'h1;
            state_d    = (ch_q == LAST_CH) ? S_SKIP : S_FAST_HI;
          end
          S_CH_HI: begin
            hold_d  = byte_data;
            state_d = S_CH_LO;
          end
          S_CH_LO: begin
            in_d[ch_q] = {hold_q, byte_data};
            if (!output_update_hold_bit_q) begin
              out_d[ch_q] = {hold_q, byte_data};
            end
            case (mode_q)
              WF_SEQ: begin
                pend_d[ch_q] = 1'b1;
                if (ch_q == LAST_CH) begin
                  nv_start = 1'b1;
                  state_d  = S_SKIP;
                end else begin
                  ch_d    = ch_q + 2'h1;
                  state_d = S_CH_HI;
                end
              end
              WF_SINGLE: begin
                pend_d[ch_q] = 1'b1;
                nv_start     = 1'b1;
                state_d      = S_SKIP;
              end
              default: begin
                state_d = S_CMD;
              end
            endcase
          end
          S_ADDR: begin
            new_addr_d = byte_data[4:2];
            addr_ok_d  = addr_ok_q && load_outputs_n_pin_low;
            state_d    = S_SKIP;
          end
          S_PD2: begin
            cfg_wr = 1'b1;
            for (int i = 0; i < NUM_CH; i++) begin
              in_d[i][FLD_PD_HI:FLD_PD_LO]  = (i < 2) ? hold_q[3-2*i -: 2] : byte_data[7-2*(i-2) -: 2];
              out_d[i][FLD_PD_HI:FLD_PD_LO] = (i < 2) ? hold_q[3-2*i -: 2] : byte_data[7-2*(i-2) -: 2];
            end
            state_d = S_SKIP;
          end
          default: begin
            state_d = S_SKIP;
          end
        endcase
      end
    end

    if (nv_start) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (pend_d[i]) begin
          nv_d[i] = in_d[i];
        end
      end
      pend_d     = '0;
      busy_cnt_d = CNT_W'(NV_WRITE_CYCLES);
    end
    if (addr_apply) begin
      addr_in_d  = new_addr_q;
      addr_nv_d  = new_addr_q;
      busy_cnt_d = CNT_W'(NV_WRITE_CYCLES);
    end

    if (load_outputs_n_pin_low) begin
      out_d = in_d;
    end
    idle_d = (busy_cnt_d == '0);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q    <= S_SKIP;
      ch_q       <= 2'h0;
      mode_q     <= WF_MULTI;
      output_update_hold_bit_q     <= 1'b0;
      hold_q     <= 8'h00;
      pend_q     <= '0;
      addr_ok_q  <= 1'b0;
      new_addr_q <= ADDR_RST;
      in_q       <= {NUM_CH{CH_RST}};
      out_q      <= {NUM_CH{CH_RST}};
      nv_q       <= {NUM_CH{CH_RST}};
      addr_in_q  <= ADDR_RST;
      addr_nv_q  <= ADDR_RST;
      busy_cnt_q <= '0;
      idle_q     <= 1'b1;
      en_q       <= CTRL_EN_RST;
    end else begin
      state_q    <= state_d;
      ch_q       <= ch_d;
      mode_q     <= mode_d;
      output_update_hold_bit_q     <= output_update_hold_bit_d;
      hold_q     <= hold_d;
      pend_q     <= pend_d;
      addr_ok_q  <= addr_ok_d;
      new_addr_q <= new_addr_d;
      in_q       <= in_d;
      out_q      <= out_d;
      nv_q       <= nv_d;
      addr_in_q  <= addr_in_d;
      addr_nv_q  <= addr_nv_d;
      busy_cnt_q <= busy_cnt_d;
      idle_q     <= idle_d;
      en_q       <= en_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read mux

  always_comb begin
    regs.rd_data = 32'h00000000;
    if (regs.rd_addr == REG_CTRL) begin
      regs.rd_data[0] = en_q;
    end else if (regs.rd_addr == REG_STATUS) begin
      regs.rd_data[ST_IDLE]                       = idle_q;
      regs.rd_data[ST_ADDR_LSB+2:ST_ADDR_LSB]     = addr_in_q;
      regs.rd_data[ST_NVADR_LSB+2:ST_NVADR_LSB]   = addr_nv_q;
    end else if (regs.rd_addr[3:2] <= LAST_CH) begin
      case (regs.rd_addr[7:4])
        REG_IN_PAGE:  regs.rd_data[CH_W-1:0] = in_q[regs.rd_addr[3:2]];
        REG_OUT_PAGE: regs.rd_data[CH_W-1:0] = out_q[regs.rd_addr[3:2]];
        REG_NV_PAGE:  regs.rd_data[CH_W-1:0] = nv_q[regs.rd_addr[3:2]];
        default:      regs.rd_data = 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_busy_count: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(idle_q) |-> (busy_cnt_q == CNT_W'(NV_WRITE_CYCLES)) ##0 (!idle_q) [*8])
    else $error("busy period too short");

  a_busy_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
    (!idle_q && byte_valid) |=> $stable(in_q) && $stable(nv_q) && $stable(addr_in_q))
    else $error("command executed while busy");

  a_pin_transfer: assert property (@(posedge hclk) disable iff (!hresetn)
    load_outputs_n_pin_low |=> out_q == in_q)
    else $error("outputs not following inputs with load pin low");

  a_cfg_outputs: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_wr |=> $stable(nv_q) && idle_q && out_q[0][FLD_GAIN] == in_q[0][FLD_GAIN]
               && out_q[3][FLD_PD_HI:FLD_VREF-3] == in_q[3][FLD_PD_HI:FLD_VREF-3])
    else $error("selection command did not reach outputs");

  a_nv_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (!nv_start && !addr_apply) |=> $stable(nv_q) && $stable(addr_nv_q))
    else $error("nonvolatile changed without a programming command");

  a_nv_start: assert property (@(posedge hclk) disable iff (!hresetn)
    nv_start |=> !idle_q && nv_q[$past(ch_q)] == in_q[$past(ch_q)])
    else $error("nonvolatile write not started");

  a_bad_cmd: assert property (@(posedge hclk) disable iff (!hresetn)
    bad_cmd |=> $stable(in_q) && $stable(nv_q) && state_q == S_SKIP && idle_q)
    else $error("undefined command changed state");

  a_addr_store: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_apply |=> addr_in_q == $past(new_addr_q) && addr_nv_q == $past(new_addr_q) && !idle_q)
    else $error("device address not stored");

  a_seq_defer: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == S_CH_LO && byte_valid && idle_q && en_q && mode_q == WF_SEQ && ch_q != LAST_CH
     && !frame_start && !frame_stop) |=> $stable(nv_q) && state_q == S_CH_HI)
    else $error("sequential write programmed too early");

endmodule // qdac_cmd_dec

// ===== bench/qdac_cmd_src.sv
// Command byte source standing in for the serial bus master
`timescale 1ns/1ps
module qdac_cmd_src import qdac_pkg::*; (
  // Clock
  input  wire logic hclk,
  // Device status
  input  wire logic nv_write_idle_flag,
  // Byte stream
  output logic       frame_start = 1'b0,
  output logic       byte_valid  = 1'b0,
  output logic [7:0] byte_data   = 8'h00,
  output logic       frame_stop  = 1'b0
);
  //////////////////////////////////////////////////////////////////////////////
  // wait for idle
  task automatic wait_idle();
    int n;
    n = 0;
    while (nv_write_idle_flag !== 1'b1 && n < 1000) begin
      @(posedge hclk);
      n++;
    end
  endtask

  // Frame of bytes; obey low sends even while busy
  task automatic send(input logic [7:0] q[$], input int gap, input bit obey);
    @(posedge hclk);
    if (obey) begin
      wait_idle();
    end
    frame_start <= 1'b1;
    @(posedge hclk);
    frame_start <= 1'b0;
    foreach (q[i]) begin
      repeat (gap) @(posedge hclk);
      byte_valid <= 1'b1;
      byte_data  <= q[i];
      @(posedge hclk);
      byte_valid <= 1'b0;
      // Released data never shows the last byte
      byte_data  <= ~q[i];
    end
    repeat (gap) @(posedge hclk);
    frame_stop <= 1'b1;
    @(posedge hclk);
    frame_stop <= 1'b0;
  endtask
endmodule // qdac_cmd_src

// ===== bench/quad_dac_write_command_decoder_bench.sv
// Self-checking bench for the quad DAC write command decoder
`timescale 1ns/1ps
module quad_dac_write_command_decoder_bench;
  import qdac_pkg::*;
  localparam int NV = 20;
  //////////////////////////////////////////////////////////////////////////////
  logic                        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, pin_n = 1'b1;
  logic [31:0]                 haddr = 32'h0, hwdata = 32'h0, hrdata, rd, r;
  logic [1:0]                  htrans = 2'h0;
  logic [2:0]                  hsize = 3'h2, dev_addr, ea;
  logic                        hreadyout, hresp, fs, bv, fp, idle;
  logic [7:0]                  bd, pdv;
  logic [7:0]                  q[$];
  logic [NUM_CH-1:0][CH_W-1:0] outs;
  logic [15:0]                 ei[NUM_CH], eo[NUM_CH], en[NUM_CH];
  int                          fail_count = 0, n_checks = 0, n;
  integer                      seed = 32'h1f66;

  always #2 hclk = ~hclk;

  qdac_cmd_dec #(.NV_WRITE_CYCLES(NV)) qdac_cmd_dec_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .frame_start(fs), .byte_valid(bv), .byte_data(bd), .frame_stop(fp),
    .load_outputs_n_pin(pin_n), .nv_write_idle_flag(idle), .dac_out_codes(outs), .device_address(dev_addr));

  qdac_cmd_src qdac_cmd_src_inst (
    .hclk(hclk), .nv_write_idle_flag(idle), .frame_start(fs), .byte_valid(bv), .byte_data(bd),
    .frame_stop(fp));
  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] d);
    @(posedge hclk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic send(input int gap);
    qdac_cmd_src_inst.send(q, gap, 1'b1);
    q = {};
  endtask

  task automatic verify(input string t);
    qdac_cmd_src_inst.wait_idle();
    for (int i = 0; i < NUM_CH; i++) begin
      ahb({24'h0, REG_IN_PAGE, 2'(i), 2'h0}, 1'b0, 32'h0, rd);
      chk("input reg", rd, {16'h0, ei[i]});
      ahb({24'h0, REG_NV_PAGE, 2'(i), 2'h0}, 1'b0, 32'h0, rd);
      chk("nv reg", rd, {16'h0, en[i]});
      chk("output reg", {16'h0, outs[i]}, {16'h0, eo[i]});
    end
    ahb({24'h0, REG_STATUS}, 1'b0, 32'h0, rd);
    chk("status", rd, {25'h0, ea, ea, 1'b1});
    $display("test %s done", t);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < NUM_CH; i++) begin
      ei[i] = CH_RST;
      eo[i] = CH_RST;
      en[i] = CH_RST;
    end
    ea = ADDR_RST;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    ahb({24'h0, REG_CTRL}, 1'b0, 32'h0, rd);
    chk("ctrl", rd, 32'h1);
    ahb(32'h80, 1'b1, 32'hFFFF_FFFF, rd);
    ahb(32'h80, 1'b0, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    verify("reset");
    // Two commands per frame, hold bit alternating
    for (int j = 0; j < 2; j++) begin
      for (int k = 2 * j; k < 2 * j + 2; k++) begin
        r = $random(seed);
        q.push_back({CMD_NVWR, WF_MULTI, 2'(k), k[0]});
        q.push_back(r[15:8]);
        q.push_back(r[7:0]);
        ei[k] = r[15:0];
        if (!k[0]) begin
          eo[k] = r[15:0];
        end
      end
      send(1 + 2 * j);
    end
    verify("multi write");
    q.push_back({CMD_NVWR, WF_SEQ, 2'h2, 1'b1});
    for (int k = 2; k < NUM_CH; k++) begin
      r = $random(seed);
      q.push_back(r[15:8]);
      q.push_back(r[7:0]);
      ei[k] = r[15:0];
      en[k] = r[15:0];
    end
    send(1);
    fork
      begin
        n = 0;
        while (idle !== 1'b1 && n < 200) begin
          @(posedge hclk);
          n++;
        end
      end
      qdac_cmd_src_inst.send('{8'h40, 8'hFF, 8'hFF}, 1, 1'b0);
    join
    chk("busy span", 32'(n >= NV - 4 && n <= NV), 32'h1);
    verify("sequential and busy");
    r = $random(seed);
    q = '{{CMD_NVWR, WF_SINGLE, 2'h1, 1'b1}, r[15:8], r[7:0]};
    send(2);
    ei[1] = r[15:0];
    en[1] = r[15:0];
    verify("single write");
    pin_n <= 1'b0;
    repeat (4) @(posedge hclk);
    eo = ei;
    q = '{{CMD_ADDR, 5'h0}, {3'h0, 3'h5, 2'h0}};
    send(1);
    ea = 3'h5;
    verify("address write");
    chk("address port", {29'h0, dev_addr}, {29'h0, ea});
    pin_n <= 1'b1;
    r = $random(seed);
    pdv = {r[11:8], r[15:12]};
    q = '{{CMD_VREF, 1'b0, r[3:0]}};
    send(1);
    q = '{{CMD_GAIN, 1'b0, r[7:4]}};
    send(1);
    q = '{{CMD_PD, 1'b0, r[11:8]}, {r[15:12], 4'h0}};
    send(1);
    for (int i = 0; i < NUM_CH; i++) begin
      ei[i][FLD_VREF]            = r[3 - i];
      ei[i][FLD_GAIN]            = r[7 - i];
      ei[i][FLD_PD_HI:FLD_PD_LO] = pdv[7 - 2 * i -: 2];
      eo[i][FLD_VREF]            = r[3 - i];
      eo[i][FLD_GAIN]            = r[7 - i];
      eo[i][FLD_PD_HI:FLD_PD_LO] = pdv[7 - 2 * i -: 2];
    end
    verify("selection commands");
    for (int i = 0; i < NUM_CH; i++) begin
      r = $random(seed);
      q.push_back({FAST_TAG, r[13:12], r[11:8]});
      q.push_back(r[7:0]);
      ei[i][14:0] = {r[13:12], ei[i][FLD_GAIN], r[11:0]};
    end
    send(1);
    verify("fast write held");
    pin_n <= 1'b0;
    repeat (4) @(posedge hclk);
    for (int i = 0; i < NUM_CH; i++) begin
      chk("fast output", {16'h0, outs[i]}, {16'h0, ei[i]});
    end
    eo    = ei;
    pin_n <= 1'b1;
    q = '{{CMD_NVWR, WF_BAD, 3'h0}, 8'hFF, 8'hFF};
    send(1);
    q = '{8'hE0, 8'hFF, 8'hFF};
    send(2);
    ahb({24'h0, REG_CTRL}, 1'b1, 32'h0, rd);
    q = '{8'h40, 8'h12, 8'h34};
    send(1);
    ahb({24'h0, REG_CTRL}, 1'b1, 32'h1, rd);
    verify("undefined and disabled");
    print_verdict();
  end

  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule // quad_dac_write_command_decoder_bench
